//--- verilog/lvd_map.vh
`ifndef LVD_MAP_VH
`define LVD_MAP_VH

// register byte offsets
`define LVD_CTRL_OFF 12'h000
`define LVD_IRQ_STAT_OFF 12'h004
`define LVD_IRQ_MASK_OFF 12'h008
`define LVD_PIN_STAT_OFF 12'h00C

// control register fields
`define LVD_RESULT_BIT 0
`define LVD_RSTMODE_BIT 1
`define LVD_SRCSEL_BIT 2
`define LVD_ENABLE_BIT 7

// reset values
`define LVD_CTRL_RST 8'h00
`define LVD_MASK_RST 2'h3

// irq status bits
`define LVD_IRQ_DETECT_BIT 0
`define LVD_IRQ_RECOVER_BIT 1

// timing
`define LVD_CLK_MHZ 100
`define LVD_STAB_US 10
`define LVD_PULSE_US 200
`define LVD_STAB_CYC (`LVD_STAB_US * `LVD_CLK_MHZ)
`define LVD_PULSE_CYC (`LVD_PULSE_US * `LVD_CLK_MHZ)

`endif

//--- verilog/lvd_apb_slave.v
`timescale 1ns/1ps
`include "lvd_map.vh"

module lvd_apb_slave (
    input wire clk_sys_i,
    input wire rstn_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [31:0] rd_word_i,
    output reg pready_o,
    output reg pslverr_o,
    output reg [31:0] prdata_o,
    output wire wr_stb_o,
    output wire rd_hit_o,
    output wire [11:0] addr_o
);
    // every access is answered in its second access cycle, after one wait state
    wire access;
    wire mapped;
    assign access = psel_i & penable_i & ~pready_o;
    assign mapped = (paddr_i == `LVD_CTRL_OFF) | (paddr_i == `LVD_IRQ_STAT_OFF) |
                    (paddr_i == `LVD_IRQ_MASK_OFF) | (paddr_i == `LVD_PIN_STAT_OFF);
    assign wr_stb_o = access & pwrite_i & mapped;
    assign rd_hit_o = access & ~pwrite_i;
    assign addr_o = paddr_i;

    always @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h00000000;
        end else begin
            pready_o <= access;
            pslverr_o <= access & ~mapped;
            if (rd_hit_o) begin
                prdata_o <= mapped ? rd_word_i : 32'h00000000;
            end
        end
    end
endmodule // lvd_apb_slave

//--- verilog/lvd_sense_filter.v
`timescale 1ns/1ps
`include "lvd_map.vh"

module lvd_sense_filter #(
    parameter STAB_CYC = `LVD_STAB_CYC,
    parameter PULSE_CYC = `LVD_PULSE_CYC
) (
    input wire clk_sys_i,
    input wire rstn_i,
    input wire enable_i,
    input wire below_i,
    output reg valid_o,
    output reg below_o
);
    // result held invalid while the comparator settles, then level must persist
    reg [15:0] stab_cnt_ff;
    reg [15:0] hold_cnt_ff;
    wire [15:0] stab_lim;
    wire [15:0] pulse_lim;
    assign stab_lim = STAB_CYC[15:0];
    assign pulse_lim = PULSE_CYC[15:0];

    always @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            stab_cnt_ff <= 16'h0000;
            hold_cnt_ff <= 16'h0000;
            valid_o <= 1'b0;
            below_o <= 1'b0;
        end else if (!enable_i) begin
            stab_cnt_ff <= 16'h0000;
            hold_cnt_ff <= 16'h0000;
            valid_o <= 1'b0;
            below_o <= 1'b0;
        end else if (!valid_o) begin
            stab_cnt_ff <= stab_cnt_ff + 16'h0001;
            if (stab_cnt_ff >= stab_lim - 16'h0001) begin
                valid_o <= 1'b1;
                below_o <= below_i;
            end
        end else if (below_i == below_o) begin
            hold_cnt_ff <= 16'h0000;
        end else if (hold_cnt_ff >= pulse_lim - 16'h0001) begin
            below_o <= below_i;
            hold_cnt_ff <= 16'h0000;
        end else begin
            hold_cnt_ff <= hold_cnt_ff + 16'h0001;
        end
    end
endmodule // lvd_sense_filter

//--- verilog/lvd_ctrl.v
`timescale 1ns/1ps
`include "lvd_map.vh"

// Function
// - control bit 2 set selects the external sense pin as the compared level.
// - control bit 7 set enables detection, written after the source select.
// - control bit 0 reports the comparison result, polled until the pin is at or above threshold.
// - with reset mode set, the block asserts internal reset when the pin falls to threshold.
// - with the mask and reset mode clear, the detector interrupt may fire once STAB_CYC settling cycles after the enable write have passed.
// - setting reset mode while the pin is above threshold does not cause a reset.
module lvd_ctrl #(
    parameter STAB_CYC = `LVD_STAB_CYC,
    parameter PULSE_CYC = `LVD_PULSE_CYC
) (
    input wire clk_sys_i,
    input wire rstn_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output wire pready_o,
    output wire pslverr_o,
    output wire [31:0] prdata_o,
    input wire ext_below_i,
    input wire supply_below_i,
    output reg external_sense_select_o,
    output reg detector_enable_o,
    output reg irq_o,
    output reg internal_reset_o
);
    reg detect_source_select_ff;
    reg detector_enable_ff;
    reg reset_mode_select_ff;
    reg [1:0] irq_stat_ff;
    reg [1:0] irq_mask_ff;
    reg prev_below_ff;
    reg [31:0] rd_word;
    reg [1:0] nxt_irq_stat;
    wire wr_stb;
    wire [11:0] addr;
    wire flt_valid;
    wire flt_below;
    wire cmp_below;
    wire result_flag;
    wire fall_evt;
    wire rise_evt;

    lvd_apb_slave u_apb (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .psel_i(psel_i),
        .penable_i(penable_i),
        .pwrite_i(pwrite_i),
        .paddr_i(paddr_i),
        .pwdata_i(pwdata_i),
        .rd_word_i(rd_word),
        .pready_o(pready_o),
        .pslverr_o(pslverr_o),
        .prdata_o(prdata_o),
        .wr_stb_o(wr_stb),
        .rd_hit_o(),
        .addr_o(addr)
    );

    assign cmp_below = detect_source_select_ff ? ext_below_i : supply_below_i;

    lvd_sense_filter #(
        .STAB_CYC(STAB_CYC),
        .PULSE_CYC(PULSE_CYC)
    ) u_flt (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .enable_i(detector_enable_ff),
        .below_i(cmp_below),
        .valid_o(flt_valid),
        .below_o(flt_below)
    );

    // flag high means below threshold; reads 0 once level is at or above it
    assign result_flag = detector_enable_ff & flt_valid & flt_below;
    // edges only after settling, so a fresh enable with a good level stays quiet
    assign fall_evt = flt_valid & flt_below & ~prev_below_ff;
    assign rise_evt = flt_valid & ~flt_below & prev_below_ff;

    always @* begin
        rd_word = 32'h00000000;
        case (addr)
            `LVD_CTRL_OFF: begin
                rd_word[`LVD_RESULT_BIT] = result_flag;
                rd_word[`LVD_RSTMODE_BIT] = reset_mode_select_ff;
                rd_word[`LVD_SRCSEL_BIT] = detect_source_select_ff;
                rd_word[`LVD_ENABLE_BIT] = detector_enable_ff;
            end
            `LVD_IRQ_STAT_OFF: rd_word[1:0] = irq_stat_ff;
            `LVD_IRQ_MASK_OFF: rd_word[1:0] = irq_mask_ff;
            `LVD_PIN_STAT_OFF: begin
                rd_word[0] = ext_below_i;
                rd_word[1] = supply_below_i;
                rd_word[2] = flt_valid;
            end
            default: rd_word = 32'h00000000;
        endcase
    end

    always @* begin
        nxt_irq_stat = irq_stat_ff;
        if (wr_stb && addr == `LVD_IRQ_STAT_OFF) begin
            nxt_irq_stat = irq_stat_ff & ~pwdata_i[1:0];
        end
        // set beats a same-cycle clear
        if (fall_evt && detector_enable_ff && !reset_mode_select_ff) begin
            nxt_irq_stat[`LVD_IRQ_DETECT_BIT] = 1'b1;
        end
        if (rise_evt && detector_enable_ff) begin
            nxt_irq_stat[`LVD_IRQ_RECOVER_BIT] = 1'b1;
        end
    end

    always @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            detect_source_select_ff <= 1'b0;
            detector_enable_ff <= 1'b0;
            reset_mode_select_ff <= 1'b0;
            irq_stat_ff <= 2'h0;
            irq_mask_ff <= `LVD_MASK_RST;
            prev_below_ff <= 1'b0;
            external_sense_select_o <= 1'b0;
            detector_enable_o <= 1'b0;
            irq_o <= 1'b0;
            internal_reset_o <= 1'b0;
        end else begin
            if (wr_stb && addr == `LVD_CTRL_OFF) begin
                detect_source_select_ff <= pwdata_i[`LVD_SRCSEL_BIT];
                detector_enable_ff <= pwdata_i[`LVD_ENABLE_BIT];
                reset_mode_select_ff <= pwdata_i[`LVD_RSTMODE_BIT];
            end
            if (wr_stb && addr == `LVD_IRQ_MASK_OFF) begin
                irq_mask_ff <= pwdata_i[1:0];
            end
            irq_stat_ff <= nxt_irq_stat;
            prev_below_ff <= flt_valid & flt_below;
            external_sense_select_o <= detect_source_select_ff;
            detector_enable_o <= detector_enable_ff;
            irq_o <= |(nxt_irq_stat & ~irq_mask_ff);
            // reset only on a fall to threshold, never from mode set alone
            internal_reset_o <= fall_evt & detector_enable_ff & reset_mode_select_ff;
        end
    end
endmodule // lvd_ctrl

//--- verification/lvd_chk.sv
`timescale 1ns/1ps
module lvd_chk (
    input wire clk_sys_i,
    input wire rstn_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire pready_o,
    input wire pslverr_o,
    input wire ext_below_i,
    input wire external_sense_select_o,
    input wire detector_enable_o,
    input wire irq_o,
    input wire internal_reset_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rstn_i);
    wire ctrl_wr = psel_i & penable_i & pwrite_i & ~pready_o & (paddr_i == 12'h000);
    chk_ready_answer: assert property (psel_i & penable_i & ~pready_o |=> pready_o)
        else $error("no pready after access cycle");
    chk_ready_single: assert property (pready_o |=> !pready_o)
        else $error("pready longer than one cycle");
    chk_err_ready: assert property (pslverr_o |-> pready_o)
        else $error("pslverr without pready");
    chk_select_copy: assert property (ctrl_wr |-> ##2 external_sense_select_o == $past(pwdata_i[2], 2))
        else $error("source select not following write");
    chk_enable_copy: assert property (ctrl_wr |-> ##2 detector_enable_o == $past(pwdata_i[7], 2))
        else $error("enable not following write");
    chk_reset_pulse: assert property (internal_reset_o |=> !internal_reset_o)
        else $error("internal reset longer than one cycle");
    // level was seen low at the accepting edge, two samples before the pulse
    chk_reset_cause: assert property (internal_reset_o && external_sense_select_o |-> detector_enable_o && $past(ext_below_i, 2))
        else $error("internal reset without low level");
    chk_irq_no_reset: assert property ($rose(irq_o) |-> !internal_reset_o)
        else $error("interrupt and reset together");
endmodule // lvd_chk
bind lvd_ctrl lvd_chk u_lvd_chk (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .ext_below_i(ext_below_i),
    .external_sense_select_o(external_sense_select_o),
    .detector_enable_o(detector_enable_o),
    .irq_o(irq_o),
    .internal_reset_o(internal_reset_o)
);

//--- verification/lvd_cmp_model.sv
`timescale 1ns/1ps
module lvd_cmp_model (
    input wire clk_sys_i,
    input wire enable_i,
    input wire below_i,
    output reg ext_below_o,
    output reg supply_below_o
);
    initial ext_below_o = 1'b0;
    initial supply_below_o = 1'b0;
    // unpowered comparator output wanders, never trust it while disabled
    always @(posedge clk_sys_i) begin
        ext_below_o <= enable_i ? below_i : ~ext_below_o;
        supply_below_o <= ~supply_below_o;
    end
endmodule // lvd_cmp_model

//--- verification/tb.sv
`timescale 1ns/1ps
module tb;
    localparam STAB = 4, PULSE = 8, SETTLE = 24;
    reg clk_sys_i = 1'b0;
    reg rstn_i = 1'b0;
    reg psel_i = 1'b0;
    reg penable_i = 1'b0;
    reg pwrite_i = 1'b0;
    reg [11:0] paddr_i = 12'h000;
    reg [31:0] pwdata_i = 32'h00000000;
    reg below = 1'b0;
    reg err;
    reg [31:0] rd;
    integer errors = 0, total_checks = 0, resets = 0, seed = 32'hF2DB1119;
    wire pready_o, pslverr_o, ext_below_i, supply_below_i;
    wire external_sense_select_o, detector_enable_o, irq_o, internal_reset_o;
    wire [31:0] prdata_o;
    lvd_ctrl #(.STAB_CYC(STAB), .PULSE_CYC(PULSE)) u_lvd_ctrl (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .psel_i(psel_i),
        .penable_i(penable_i),
        .pwrite_i(pwrite_i),
        .paddr_i(paddr_i),
        .pwdata_i(pwdata_i),
        .pready_o(pready_o),
        .pslverr_o(pslverr_o),
        .prdata_o(prdata_o),
        .ext_below_i(ext_below_i),
        .supply_below_i(supply_below_i),
        .external_sense_select_o(external_sense_select_o),
        .detector_enable_o(detector_enable_o),
        .irq_o(irq_o),
        .internal_reset_o(internal_reset_o)
    );
    lvd_cmp_model u_lvd_cmp_model (.clk_sys_i(clk_sys_i), .enable_i(detector_enable_o), .below_i(below),
        .ext_below_o(ext_below_i), .supply_below_o(supply_below_i));
    always #5 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) if (internal_reset_o === 1'b1) resets = resets + 1;
    task finish_test;
        begin
            $display("checks %0d errors %0d", total_checks, errors);
            if (errors == 0 && total_checks > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    task check(input [31:0] seen, input [31:0] exp, input [8*12:1] what);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("unexpected %0s: expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    // unused control bits get random fill, result bit kept clear
    function [31:0] rnd(input [7:0] v);
        rnd = ($random(seed) & 32'hFFFFFF78) | v;
    endfunction
    task apb(input w, input [11:0] a, input [31:0] d);
        integer n;
        begin
            @(posedge clk_sys_i);
            psel_i <= 1'b1;
            pwrite_i <= w;
            paddr_i <= a;
            pwdata_i <= d;
            @(posedge clk_sys_i);
            penable_i <= 1'b1;
            n = 0;
            @(posedge clk_sys_i);
            while (pready_o !== 1'b1 && n < 20) begin
                @(posedge clk_sys_i);
                n = n + 1;
            end
            if (n == 20) begin
                errors = errors + 1;
                finish_test;
            end
            rd = prdata_o;
            err = pslverr_o;
            psel_i <= 1'b0;
            penable_i <= 1'b0;
            repeat (2) @(posedge clk_sys_i);
        end
    endtask
    initial begin
        repeat (16) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        apb(0, 12'h008, 0);
        check(rd, 32'h3, "mask reset");
        apb(0, 12'h000, 0);
        check(rd, 32'h0, "ctrl reset");
        apb(0, 12'h010, 0);
        check(err, 1, "unmapped");
        apb(1, 12'h008, 3);
        apb(1, 12'h000, rnd(8'h04));
        check(external_sense_select_o, 1, "select");
        apb(1, 12'h000, rnd(8'h84));
        check(detector_enable_o, 1, "enable");
        repeat (SETTLE) @(posedge clk_sys_i);
        apb(0, 12'h000, 0);
        check(rd[0], 0, "above");
        apb(1, 12'h000, rnd(8'h86));
        repeat (SETTLE) @(posedge clk_sys_i);
        check(resets, 0, "no reset");
        below <= 1'b1;
        repeat (SETTLE) @(posedge clk_sys_i);
        check(resets, 1, "reset");
        apb(0, 12'h000, 0);
        check(rd[0], 1, "below");
        below <= 1'b0;
        repeat (SETTLE) @(posedge clk_sys_i);
        apb(1, 12'h000, rnd(8'h84));
        apb(1, 12'h000, rnd(8'h04));
        check(detector_enable_o, 0, "stop");
        check(external_sense_select_o, 1, "stop select");
        apb(1, 12'h008, 2);
        apb(1, 12'h000, rnd(8'h84));
        repeat (SETTLE) @(posedge clk_sys_i);
        below <= 1'b1;
        repeat (SETTLE) @(posedge clk_sys_i);
        check(irq_o, 1, "irq");
        check(resets, 1, "irq no rst");
        apb(1, 12'h008, 3);
        check(irq_o, 0, "masked");
        apb(1, 12'h008, 2);
        check(irq_o, 1, "unmasked");
        apb(0, 12'h004, 0);
        check(rd, 32'h3, "irq status");
        apb(1, 12'h004, 1);
        check(irq_o, 0, "cleared");
        apb(0, 12'h004, 0);
        check(rd, 32'h2, "stat clear");
        // supply as source: its level never persists long enough to act
        apb(1, 12'h000, rnd(8'h80));
        check(external_sense_select_o, 0, "supply sel");
        repeat (SETTLE) @(posedge clk_sys_i);
        check(resets, 1, "supply rst");
        finish_test;
    end
endmodule // tb
